// ### src/bdft_consts.vh
// constants for the bidirectional dual fifo transceiver
// assumes inclusion by plain verilog design files
`ifndef BDFT_CONSTS_VH
`define BDFT_CONSTS_VH
`define BDFT_DEPTH        1024
`define BDFT_WIDTH        9
`define BDFT_CNT_W        11
`define BDFT_PTR_W        10
`define BDFT_HALF_LEVEL   11'h200
`define BDFT_DEF_OFFSET   9'h100
`define BDFT_FULL_COUNT   11'h400
// pin synchroniser reset: drive-enable bit high, so no bus is driven in reset
`define BDFT_SYNC_RST     11'h200
`endif

// ### src/bdft_fifo.v
// one direction: storage, pointers, occupancy count and the four flags
// assumes strobes and reset already synchronised and edge-detected on mclk
`timescale 1ns/1ps
`include "bdft_consts.vh"
module bdft_fifo #(
  parameter WIDTH = `BDFT_WIDTH,
  parameter DEPTH = `BDFT_DEPTH
) (
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             dir_reset,
  input  wire             wr_pulse,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             rd_pulse,
  input  wire             def_fall,
  input  wire             def_level_n,
  input  wire [WIDTH-1:0] def_data,
  output reg  [WIDTH-1:0] rd_data_q,
  output reg              empty_n_q,
  output reg              full_n_q,
  output reg              half_q,
  output reg              near_q
);
  reg [WIDTH-1:0]           mem_q [0:DEPTH-1];
  reg [`BDFT_PTR_W-1:0]     wp_q;
  reg [`BDFT_PTR_W-1:0]     rp_q;
  reg [`BDFT_CNT_W-1:0]     cnt_q;
  reg [`BDFT_CNT_W-1:0]     cnt_d;
  reg [WIDTH-1:0]           cap_q;
  reg [WIDTH-1:0]           off_q;
  reg                       dir_reset_q;
  wire                      do_wr;
  wire                      do_rd;
  wire [`BDFT_CNT_W-1:0]    off_ext;

  assign do_wr   = wr_pulse && (cnt_q != `BDFT_FULL_COUNT);
  assign do_rd   = rd_pulse && (cnt_q != {`BDFT_CNT_W{1'b0}});
  assign off_ext = {2'h0, off_q};

  // ****************************************
  // storage and pointers
  // ****************************************
  always @(posedge mclk) begin
    if (do_wr) begin
      mem_q[wp_q] <= wr_data;
    end
  end

  always @* begin
    cnt_d = cnt_q;
    if (do_wr && !do_rd) begin
      cnt_d = cnt_q + 11'h001;
    end else if (do_rd && !do_wr) begin
      cnt_d = cnt_q - 11'h001;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n || dir_reset) begin
      wp_q      <= 10'h000;
      rp_q      <= 10'h000;
      cnt_q     <= 11'h000;
    end else begin
      cnt_q <= cnt_d;
      if (do_wr) begin
        wp_q <= wp_q + 10'h001;
      end
      if (do_rd) begin
        rp_q      <= rp_q + 10'h001;
      end
    end
  end

  // direction reset leaves the last word on the output path
  always @(posedge mclk) begin
    if (!reset_n) begin
      rd_data_q <= 9'h000;
    end else if (do_rd && !dir_reset) begin
      rd_data_q <= mem_q[rp_q];
    end
  end

  // ****************************************
  // offset capture and threshold set-up
  // ****************************************
  // captured value survives resets; only the power-on reset returns it to 256
  always @(posedge mclk) begin
    if (!reset_n) begin
      cap_q       <= `BDFT_DEF_OFFSET;
      off_q       <= `BDFT_DEF_OFFSET;
      dir_reset_q <= 1'b0;
    end else begin
      dir_reset_q <= dir_reset;
      if (def_fall) begin
        cap_q <= def_data;
      end
      // threshold fixed at the release of the direction reset
      if (dir_reset_q && !dir_reset) begin
        off_q <= def_level_n ? `BDFT_DEF_OFFSET : cap_q;
      end
    end
  end

  // ****************************************
  // flags
  // ****************************************
  always @(posedge mclk) begin
    if (!reset_n || dir_reset) begin
      empty_n_q <= 1'b0;
      half_q    <= 1'b0;
      full_n_q  <= 1'b1;
      near_q    <= 1'b1;
    end else begin
      empty_n_q <= (cnt_d != 11'h000);
      full_n_q  <= (cnt_d != `BDFT_FULL_COUNT);
      half_q    <= (cnt_d >= `BDFT_HALF_LEVEL);
      near_q    <= (cnt_d <= off_ext) || (cnt_d >= (`BDFT_FULL_COUNT - off_ext));
    end
  end
endmodule // bdft_fifo

// ### src/bdft_top.v
// top: two fifo directions, pin synchronisers, bus transceivers and muxes
// assumes all strobes and controls are asynchronous pins sampled on mclk
// How it works
// - reset drives empty/half low, full/near high
// - each direction stores 1024 nine-bit words
// - write strobe rising edge loads bus word
// - writes ignored while fifo full
// - read strobe rising edge presents next word
// - reads ignored while fifo empty
// - drive enable high releases both buses
// - enabled, side select high drives b bus
// - enabled, side select low drives a bus
// - source select low live, high stored
// - mux switches without glitch on bus
// - define falling edge captures bus as offset
// - empty flag low only when fifo empty
// - full flag low only when fifo full
// - half flag high at 512 or more
// - near flag high near either end
// - threshold set each reset, captured or 256
// - last read word stays on output
`timescale 1ns/1ps
`include "bdft_consts.vh"
module bdft_top #(
  parameter WIDTH = `BDFT_WIDTH,
  parameter DEPTH = `BDFT_DEPTH
) (
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             reset_a_n,
  input  wire             reset_b_n,
  input  wire             write_strobe_a,
  input  wire             write_strobe_b,
  input  wire             read_strobe_a,
  input  wire             read_strobe_b,
  input  wire             stored_select_a_to_b,
  input  wire             stored_select_b_to_a,
  input  wire             define_offset_a_n,
  input  wire             define_offset_b_n,
  input  wire             bus_drive_n,
  input  wire             drive_b_side,
  input  wire [WIDTH-1:0] port_a_bus_in,
  output reg  [WIDTH-1:0] port_a_bus_out,
  output wire             port_a_bus_oe_n,
  input  wire [WIDTH-1:0] port_b_bus_in,
  output reg  [WIDTH-1:0] port_b_bus_out,
  output wire             port_b_bus_oe_n,
  output wire             empty_a_n,
  output wire             empty_b_n,
  output wire             full_a_n,
  output wire             full_b_n,
  output wire             half_level_a,
  output wire             half_level_b,
  output wire             near_limit_a,
  output wire             near_limit_b
);
  localparam NSYNC = 11;
  localparam DW    = 2 * WIDTH;

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [NSYNC-1:0] raw;
  reg  [NSYNC-1:0] s1_q;
  reg  [NSYNC-1:0] s2_q;
  reg  [NSYNC-1:0] s3_q;
  reg  [DW-1:0]    d1_q;
  reg  [DW-1:0]    d2_q;
  reg  [DW-1:0]    d3_q;
  wire [WIDTH-1:0] a_live;
  wire [WIDTH-1:0] b_live;
  wire [WIDTH-1:0] a_late;
  wire [WIDTH-1:0] b_late;

  assign raw = {drive_b_side, bus_drive_n, stored_select_b_to_a, stored_select_a_to_b,
                define_offset_b_n, define_offset_a_n, read_strobe_b, read_strobe_a,
                write_strobe_b, write_strobe_a, 1'b0};

  // s3 keeps the previous synced value for edge detection; s1 feeds only s2
  always @(posedge mclk) begin
    if (!reset_n) begin
      // define bits reset low: no false define fall at reset release
      s1_q <= `BDFT_SYNC_RST;
      s2_q <= `BDFT_SYNC_RST;
      s3_q <= `BDFT_SYNC_RST;
      d1_q <= 18'h00000;
      d2_q <= 18'h00000;
      d3_q <= 18'h00000;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      d1_q <= {port_b_bus_in, port_a_bus_in};
      d2_q <= d1_q;
      d3_q <= d2_q;
    end
  end

  // data pipeline is one stage deeper so it lines up with the strobe edge
  assign a_live = d2_q[WIDTH-1:0];
  assign b_live = d2_q[DW-1:WIDTH];
  assign a_late = d3_q[WIDTH-1:0];
  assign b_late = d3_q[DW-1:WIDTH];

  reg rst_a1_q;
  reg rst_a2_q;
  reg rst_b1_q;
  reg rst_b2_q;

  always @(posedge mclk) begin
    if (!reset_n) begin
      rst_a1_q <= 1'b0;
      rst_a2_q <= 1'b0;
      rst_b1_q <= 1'b0;
      rst_b2_q <= 1'b0;
    end else begin
      rst_a1_q <= reset_a_n;
      rst_a2_q <= rst_a1_q;
      rst_b1_q <= reset_b_n;
      rst_b2_q <= rst_b1_q;
    end
  end

  wire [NSYNC-1:0] rise;
  wire [NSYNC-1:0] fall;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

  // ****************************************
  // the two directions
  // ****************************************
  wire [WIDTH-1:0] stored_a;
  wire [WIDTH-1:0] stored_b;

  bdft_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo_a (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .dir_reset   (!rst_a2_q),
    .wr_pulse    (rise[1]),
    .wr_data     (a_late),
    .rd_pulse    (rise[3]),
    .def_fall    (fall[5]),
    .def_level_n (s2_q[5]),
    .def_data    (a_late),
    .rd_data_q   (stored_a),
    .empty_n_q   (empty_a_n),
    .full_n_q    (full_a_n),
    .half_q      (half_level_a),
    .near_q      (near_limit_a)
  );

  bdft_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo_b (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .dir_reset   (!rst_b2_q),
    .wr_pulse    (rise[2]),
    .wr_data     (b_late),
    .rd_pulse    (rise[4]),
    .def_fall    (fall[6]),
    .def_level_n (s2_q[6]),
    .def_data    (b_late),
    .rd_data_q   (stored_b),
    .empty_n_q   (empty_b_n),
    .full_n_q    (full_b_n),
    .half_q      (half_level_b),
    .near_q      (near_limit_b)
  );

  // ****************************************
  // output muxes and transceiver enables
  // ****************************************
  // registered mux output: a select change cannot leave a decode glitch
  always @(posedge mclk) begin
    if (!reset_n) begin
      port_a_bus_out <= 9'h000;
      port_b_bus_out <= 9'h000;
    end else begin
      port_b_bus_out <= s2_q[7] ? stored_a : a_live;
      port_a_bus_out <= s2_q[8] ? stored_b : b_live;
    end
  end

  // while driving a side, its own input still reads back our drive
  assign port_a_bus_oe_n = s2_q[9] | s2_q[10];
  assign port_b_bus_oe_n = s2_q[9] | ~s2_q[10];
endmodule // bdft_top

// ### sim/bdft_top_asserts.sv
// checker for fifo a flags, transceiver enables and output paths
// assumes mclk at 100 MHz; bound to every bdft_top
`timescale 1ns/1ps
module bdft_chk #(
  parameter WIDTH = 9
) (
  input wire logic             mclk,
  input wire logic             reset_n,
  input wire logic             reset_a_n,
  input wire logic             stored_select_a_to_b,
  input wire logic             bus_drive_n,
  input wire logic             drive_b_side,
  input wire logic [WIDTH-1:0] port_a_bus_in,
  input wire logic [WIDTH-1:0] port_b_bus_out,
  input wire logic             port_a_bus_oe_n,
  input wire logic             port_b_bus_oe_n,
  input wire logic             empty_a_n,
  input wire logic             full_a_n,
  input wire logic             half_level_a,
  input wire logic             near_limit_a
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // four samples cover the two-stage pin synchroniser plus the flag register
  AST_DIR_RESET: assert property (!reset_a_n [*4] |->
    !empty_a_n && full_a_n && !half_level_a && near_limit_a) else $error("reset flags");
  AST_ALL_OFF: assert property (bus_drive_n [*4] |->
    port_a_bus_oe_n && port_b_bus_oe_n) else $error("bus not released");
  AST_DRIVE_B: assert property ((!bus_drive_n && drive_b_side) [*4] |->
    port_a_bus_oe_n && !port_b_bus_oe_n) else $error("b side drive");
  AST_DRIVE_A: assert property ((!bus_drive_n && !drive_b_side) [*4] |->
    !port_a_bus_oe_n && port_b_bus_oe_n) else $error("a side drive");
  AST_LIVE: assert property ((!stored_select_a_to_b && $stable(port_a_bus_in)) [*6] |->
    port_b_bus_out == port_a_bus_in) else $error("live path");
  AST_EMPTY: assert property (!empty_a_n |->
    full_a_n && !half_level_a && near_limit_a) else $error("empty flags");
  AST_FULL: assert property (!full_a_n |->
    empty_a_n && half_level_a && near_limit_a) else $error("full flags");
  AST_HOLD: assert property ((!empty_a_n && stored_select_a_to_b) [*6] |->
    $stable(port_b_bus_out)) else $error("stored word moved");
endmodule // bdft_chk
bind bdft_top bdft_chk #(.WIDTH(WIDTH)) bdft_chk_inst (.mclk, .reset_n, .reset_a_n,
  .stored_select_a_to_b, .bus_drive_n, .drive_b_side, .port_a_bus_in, .port_b_bus_out,
  .port_a_bus_oe_n, .port_b_bus_oe_n, .empty_a_n, .full_a_n, .half_level_a, .near_limit_a);

// ### sim/bdft_bus_sys.sv
// far-side bus system: drives its bus only while the device releases it
// assumes oe_n low means the device drives the bus
`timescale 1ns/1ps
module bdft_bus_sys (
  input  wire logic       oe_n,
  input  wire logic [8:0] dev_q,
  input  wire logic [8:0] sys_d,
  output wire logic [8:0] lvl
);
  assign lvl = oe_n ? sys_d : dev_q;
endmodule // bdft_bus_sys

// ### sim/test_bdft_top.sv
// bench: fill and drain fifo a, offsets, live paths, fifo b
// assumes bdft_top and two bdft_bus_sys far-side systems
`timescale 1ns/1ps
module test_bdft_top;
  logic       mclk, reset_n, reset_a_n, reset_b_n, sel_ab, sel_ba, def_a_n, def_b_n;
  logic       bus_drive_n, drv_b;
  logic [3:0] stb;
  logic [8:0] sys_a, sys_b, lvl_a, lvl_b, out_a, out_b, d;
  logic [9:0] n;
  wire        oe_a_n, oe_b_n, ea, eb, fa, fb, ha, hb, na, nb;
  integer     fail_count = 0, num_checks = 0, seed = 32'h769e, cnt = 0, off = 256;
  logic [9:0] notes[$];
  logic [8:0] mq[$];
  event       shown;
  bdft_top bdft_top_inst (.mclk, .reset_n, .reset_a_n, .reset_b_n, .write_strobe_a(stb[0]),
    .write_strobe_b(stb[1]), .read_strobe_a(stb[2]), .read_strobe_b(stb[3]),
    .stored_select_a_to_b(sel_ab), .stored_select_b_to_a(sel_ba), .define_offset_a_n(def_a_n),
    .define_offset_b_n(def_b_n), .bus_drive_n, .drive_b_side(drv_b), .port_a_bus_in(lvl_a),
    .port_a_bus_out(out_a), .port_a_bus_oe_n(oe_a_n), .port_b_bus_in(lvl_b),
    .port_b_bus_out(out_b), .port_b_bus_oe_n(oe_b_n), .empty_a_n(ea), .empty_b_n(eb),
    .full_a_n(fa), .full_b_n(fb), .half_level_a(ha), .half_level_b(hb), .near_limit_a(na),
    .near_limit_b(nb));
  bdft_bus_sys bdft_bus_sys_a_inst (.oe_n(oe_a_n), .dev_q(out_a), .sys_d(sys_a), .lvl(lvl_a));
  bdft_bus_sys bdft_bus_sys_b_inst (.oe_n(oe_b_n), .dev_q(out_b), .sys_d(sys_b), .lvl(lvl_b));
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task automatic cyc(input integer k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // strobe held high three cycles and low four, past the synchroniser and the answer
  task automatic pulse(input integer k);
    stb[k] = 1;
    cyc(3);
    stb[k] = 0;
    cyc(4);
  endtask
  function automatic logic [8:0] fl(input integer c);
    fl = {5'h0, c != 0, c != 1024, c >= 512, c <= off || c >= 1024 - off};
  endfunction
  task automatic wr_a;
    sys_a = 9'($random(seed));
    cyc(1);
    if (cnt < 1024) begin
      mq.push_back(sys_a);
      cnt++;
    end
    pulse(0);
    chk({5'h0, ea, fa, ha, na}, fl(cnt));
  endtask
  task automatic rd_a;
    if (cnt > 0) begin
      d = mq.pop_front();
      cnt--;
    end
    notes.push_back({1'b0, d});
    pulse(2);
    -> shown;
    chk({5'h0, ea, fa, ha, na}, fl(cnt));
  endtask
  initial forever begin
    @shown;
    n = notes.pop_front();
    chk(n[9] ? out_a : out_b, n[8:0]);
  end
  initial begin
    #400000;
    fail_count++;
    $display("Error %0t: timeout", $time);
    end_sim;
  end
  initial begin
    {reset_n, reset_a_n, reset_b_n, stb, sel_ab, sel_ba, d} = 0;
    {def_a_n, def_b_n, bus_drive_n, drv_b} = 4'hF;
    {sys_a, sys_b} = 18'h00000;
    cyc(10);
    reset_n = 1;
    cyc(5);
    chk({5'h0, ea, fa, ha, na}, 9'h005);
    chk({5'h0, eb, fb, hb, nb}, 9'h005);
    {reset_a_n, reset_b_n} = 2'b11;
    cyc(4);
    chk({7'h0, oe_a_n, oe_b_n}, 9'h003);
    bus_drive_n = 0;
    sel_ab = 1;
    cyc(4);
    chk({7'h0, oe_a_n, oe_b_n}, 9'h002);
    repeat (1025) wr_a;
    repeat (1025) rd_a;
    sys_a = 9'h003;
    cyc(2);
    def_a_n = 0;
    off = 3;
    // second pass keeps define low, so the captured offset must survive
    repeat (2) begin
      reset_a_n = 0;
      cyc(5);
      reset_a_n = 1;
      mq.delete();
      cnt = 0;
      cyc(4);
      repeat (5) wr_a;
    end
    sel_ab = 0;
    sys_a = 9'($random(seed));
    cyc(6);
    chk(out_b, sys_a);
    drv_b = 0;
    sys_b = 9'($random(seed));
    cyc(4);
    chk({7'h0, oe_a_n, oe_b_n}, 9'h001);
    // offset zero on fifo b: one word already clears the near flag
    sys_b = 9'h000;
    cyc(2);
    def_b_n = 0;
    reset_b_n = 0;
    cyc(5);
    reset_b_n = 1;
    sys_b = 9'($random(seed));
    cyc(5);
    pulse(1);
    chk({5'h0, eb, fb, hb, nb}, 9'h00C);
    sel_ba = 1;
    notes.push_back({1'b1, sys_b});
    pulse(3);
    -> shown;
    cyc(2);
    sel_ba = 0;
    sys_b = 9'($random(seed));
    cyc(6);
    chk(out_a, sys_b);
    end_sim;
  end
endmodule // test_bdft_top
